//--- hdl/bchm_top.sv
/*
  Clock distribution, clock-run, hot-swap, GPIO, EEPROM and scan pin
  control of a two-port bridge, with an Avalon-MM register slave.
  Assumes one clock ref_clk (the primary clock); all pins arrive
  asynchronously and the board resolves two-way pins from the enables.
*/
`timescale 1ns/10ps

// Behaviour
// - five downstream clock outputs derived from and locked to ref_clk.
// - each downstream clock output has its own disable bit.
// - primary logic on ref_clk; downstream clock input only observed.
// - async mode holds generated clocks off; agents use input clock.
// - upstream clock-run low means primary clock always running.
// - downstream clock-run follows upstream, or bit 5 of byte 6Fh when bit 4 of byte 6Fh is set.
// - hot-swap status output asserted on insertion or extraction event.
// - LED pin driven to show insertion or removal-ready status.
// - every 500us LED pin released 8 cycles and sampled.
// - ejector input low signals insertion or impending extraction.
// - strap high and D3hot: bus to B2, clocks stopped at 0.
// - strap low: D3hot leaves downstream clocks unchanged.
// - four GPIO pins, each input-only or bidirectional by enable bit.
// - scan test mode high makes scan enable an output driving 0.
// - EEPROM serial clock output and tri-stateable serial data pin.
module bchm_top import bchm_pkg::*; #(
  parameter int LED_PERIOD = LED_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Clocks and clock-run
  input  wire logic        downstream_clock_in,
  output logic      [4:0]  downstream_clock_out,
  input  wire logic        upstream_clock_run_n,
  input  wire logic        downstream_clock_run_n_in,
  output logic             downstream_clock_run_n_out,
  output logic             downstream_clock_run_n_oe,
  // Hot-swap
  output logic             hotswap_status_n,
  input  wire logic        hotswap_led_pin_in,
  output logic             hotswap_led_pin_out,
  output logic             hotswap_led_pin_oe,
  input  wire logic        ejector_n,
  // EEPROM
  output logic             eeprom_serial_clock,
  input  wire logic        eeprom_serial_data_in,
  output logic             eeprom_serial_data_out,
  output logic             eeprom_serial_data_oe,
  // General-purpose pins
  input  wire logic [3:0]  gpio_in,
  output logic      [3:0]  gpio_out,
  output logic      [3:0]  gpio_oe,
  // Straps and scan
  input  wire logic        power_clock_gate_strap,
  input  wire logic        scan_test_mode_n,
  output logic             scan_enable_out,
  output logic             scan_enable_oe
);

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic            prev_dclk;
    logic [4:0]      idle_cnt;
    logic            dclk_alive;
    logic            strap_taken;
    logic            strap;
    logic [15:0]     led_tmr;
    logic [3:0]      led_win;
    logic            led_sample;
    logic            ej_prev;
    logic [3:0]      gpio_prev;
    logic [11:0]     ctrl;
    logic [7:0]      gpio;
    logic [1:0]      clkrun;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic            toggle;
    logic [4:0]      ck_out;
    logic            irq;
    logic            hs_n;
    logic            led_oe;
    logic            led_out;
    logic            ee_clk;
    logic            ee_do;
    logic            ee_oe;
    logic [3:0]      gpio_do;
    logic [3:0]      gpio_oe;
    logic            dcr_out;
    logic            dcr_oe;
    logic            scan_oe;
    logic            scan_s1;
    logic            scan_s2;
    logic            wait_r;
    logic [31:0]     rdata;
  } bchm_state_type;

  bchm_state_type st_r;
  bchm_state_type st_nxt;

  logic [SY_W-1:0] pins;

  assign pins = {gpio_in, power_clock_gate_strap, eeprom_serial_data_in,
                 ejector_n, hotswap_led_pin_in, downstream_clock_run_n_in,
                 upstream_clock_run_n, downstream_clock_in};

  always_comb begin
    logic [SY_W-1:0]  s;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic             gate;
    logic             b2;
    logic             take;
    logic [31:0]      rd;
    s      = st_r.sync2;
    ev     = '0;
    clr    = '0;
    gate   = 1'b0;
    b2     = 1'b0;
    take   = 1'b0;
    rd     = 32'h0000_0000;
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;

    // downstream clock input watched, not used as a clock
    st_nxt.prev_dclk = s[SY_DCLK];
    if (s[SY_DCLK] != st_r.prev_dclk) begin
      st_nxt.idle_cnt = 5'h00;
    end else if (st_r.idle_cnt != 5'(CLK_ALIVE_LIMIT)) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 5'h01;
    end
    st_nxt.dclk_alive = (st_r.idle_cnt != 5'(CLK_ALIVE_LIMIT));

    // Strap caught once after reset release
    if (!st_r.strap_taken) begin
      st_nxt.strap_taken = 1'b1;
      st_nxt.strap       = s[SY_STRAP];
    end

    // strap high and D3hot gate the clocks, bus in B2
    // strap low leaves the clocks alone
    gate = st_r.strap && st_r.strap_taken &&
           (st_r.ctrl[CTRL_PSTATE_LSB +: 2] == PSTATE_D3HOT);
    b2   = gate;

    // divided clock, one toggle flop shared by all outputs
    st_nxt.toggle = ~st_r.toggle;
    for (int i = 0; i < 5; i++) begin
      // async mode keeps generated clocks low
      st_nxt.ck_out[i] = st_nxt.toggle & ~st_r.ctrl[CTRL_CLKDIS_LSB + i] &
                         ~st_r.ctrl[CTRL_ASYNC] & ~gate;
    end

    st_nxt.dcr_oe = 1'b1;
    if (st_r.clkrun[0]) begin
      st_nxt.dcr_out = st_r.clkrun[1];
    end else begin
      st_nxt.dcr_out = s[SY_UCR];
    end

    // periodic release of the LED pin for sampling
    if (st_r.led_win != 4'h0) begin
      st_nxt.led_win = st_r.led_win - 4'h1;
      if (st_r.led_win == 4'h1) begin
        // sample held until the next window
        st_nxt.led_sample = s[SY_LED];
        ev[IRQ_LED]       = 1'b1;
      end
    end
    if (st_r.led_tmr == 16'(LED_PERIOD - 1)) begin
      st_nxt.led_tmr = 16'h0000;
      st_nxt.led_win = 4'(LED_WINDOW_CYC);
    end else begin
      st_nxt.led_tmr = st_r.led_tmr + 16'h0001;
    end
    st_nxt.led_oe = (st_nxt.led_win == 4'h0);
    st_nxt.led_out = st_r.ctrl[CTRL_LED_ON];

    // ejector falling edge is a hot-swap event
    st_nxt.ej_prev = s[SY_EJECT];
    if (st_r.ej_prev && !s[SY_EJECT]) begin
      ev[IRQ_EJECT] = 1'b1;
    end

    // GPIO input change event, output enables per pin
    st_nxt.gpio_prev = s[SY_GPIO +: 4];
    if (st_r.gpio_prev != s[SY_GPIO +: 4]) begin
      ev[IRQ_GPIO] = 1'b1;
    end
    st_nxt.gpio_do = st_r.gpio[3:0];
    st_nxt.gpio_oe = st_r.gpio[7:4];

    // EEPROM pins steered by control bits
    st_nxt.ee_clk = st_r.ctrl[CTRL_EE_CLK];
    st_nxt.ee_do  = st_r.ctrl[CTRL_EE_DO];
    st_nxt.ee_oe  = st_r.ctrl[CTRL_EE_OE];

    // scan enable driven low in normal operation
    st_nxt.scan_s1 = scan_test_mode_n;
    st_nxt.scan_s2 = st_r.scan_s1;
    st_nxt.scan_oe = st_r.scan_s2;

    // Register read view
    if (avs_address == OFS_CTRL) begin
      rd[11:0] = st_r.ctrl;
    end else if (avs_address == OFS_GPIO) begin
      rd[7:0] = st_r.gpio;
    end else if (avs_address == OFS_STATUS) begin
      rd[3:0] = s[SY_GPIO +: 4];
      rd[4]   = st_r.led_sample;
      rd[5]   = st_r.strap;
      // clock-run low reads as primary clock free-running
      rd[6]   = ~s[SY_UCR];
      rd[7]   = st_r.dclk_alive;
      rd[8]   = s[SY_EE];
      rd[9]   = b2;
      rd[10]  = s[SY_DCR];
    end else if (avs_address == OFS_IRQ_STAT) begin
      rd[IRQ_W-1:0] = st_r.irq_stat;
    end else if (avs_address == OFS_IRQ_EN) begin
      rd[IRQ_W-1:0] = st_r.irq_en;
    end else if (avs_address == OFS_CLKRUN) begin
      rd[CLKRUN_SEL] = st_r.clkrun[0];
      rd[CLKRUN_VAL] = st_r.clkrun[1];
    end

    // Avalon handshake: one wait cycle, transfer on waitrequest low
    take = (avs_read || avs_write) && !st_r.wait_r;
    if ((avs_read || avs_write) && st_r.wait_r) begin
      st_nxt.wait_r = 1'b0;
      st_nxt.rdata  = rd;
    end else begin
      st_nxt.wait_r = 1'b1;
    end
    if (take && avs_write) begin
      if (avs_address == OFS_CTRL) begin
        st_nxt.ctrl = avs_writedata[11:0];
      end else if (avs_address == OFS_GPIO) begin
        st_nxt.gpio = avs_writedata[7:0];
      end else if (avs_address == OFS_IRQ_CLR) begin
        clr = avs_writedata[IRQ_W-1:0];
      end else if (avs_address == OFS_IRQ_EN) begin
        st_nxt.irq_en = avs_writedata[IRQ_W-1:0];
      end else if (avs_address == OFS_CLKRUN) begin
        st_nxt.clkrun = {avs_writedata[CLKRUN_VAL],
                         avs_writedata[CLKRUN_SEL]};
      end
    end

    // Sticky events, set wins over clear
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_en);
    // status low while an ejector event is pending
    st_nxt.hs_n     = ~st_nxt.irq_stat[IRQ_EJECT];

    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.sync1   = pins;
      // Synchronisers and edge history run on, no false edge at release
      st_nxt.sync2     = st_r.sync1;
      st_nxt.prev_dclk = s[SY_DCLK];
      st_nxt.ej_prev   = s[SY_EJECT];
      st_nxt.gpio_prev = s[SY_GPIO +: 4];
      st_nxt.ctrl    = CTRL_RESET;
      st_nxt.gpio    = GPIO_RESET;
      st_nxt.clkrun  = CLKRUN_RESET;
      st_nxt.hs_n    = 1'b1;
      st_nxt.led_oe  = 1'b1;
      st_nxt.dcr_out = 1'b1;
      st_nxt.wait_r  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign avs_readdata               = st_r.rdata;
  assign avs_waitrequest            = st_r.wait_r;
  assign irq                        = st_r.irq;
  assign downstream_clock_out       = st_r.ck_out;
  assign downstream_clock_run_n_out = st_r.dcr_out;
  assign downstream_clock_run_n_oe  = st_r.dcr_oe;
  assign hotswap_status_n           = st_r.hs_n;
  assign hotswap_led_pin_out        = st_r.led_out;
  assign hotswap_led_pin_oe         = st_r.led_oe;
  assign eeprom_serial_clock        = st_r.ee_clk;
  assign eeprom_serial_data_out     = st_r.ee_do;
  assign eeprom_serial_data_oe      = st_r.ee_oe;
  assign gpio_out                   = st_r.gpio_do;
  assign gpio_oe                    = st_r.gpio_oe;
  assign scan_enable_out            = 1'b0;
  assign scan_enable_oe             = st_r.scan_oe;

endmodule

//--- hdl/bchm_pkg.sv
/*
  Constants for the bridge clock, hot-swap and miscellaneous pin block:
  register offsets, field positions, reset values, timing counts.
  Assumes a 50 MHz primary clock and a 32-bit Avalon-MM register bus.
*/
package bchm_pkg;
  // Clock rate and timing
  localparam int CLK_MHZ         = 50;
  localparam int LED_PERIOD_US   = 500;
  localparam int LED_PERIOD_CYC  = LED_PERIOD_US * CLK_MHZ;
  localparam int LED_WINDOW_CYC  = 8;
  localparam int CLK_ALIVE_LIMIT = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_GPIO     = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFS_CLKRUN   = 8'h6c;

  // Control register fields
  localparam int CTRL_CLKDIS_LSB = 0;
  localparam int CTRL_ASYNC      = 5;
  localparam int CTRL_PSTATE_LSB = 6;
  localparam int CTRL_LED_ON     = 8;
  localparam int CTRL_EE_CLK     = 9;
  localparam int CTRL_EE_DO      = 10;
  localparam int CTRL_EE_OE      = 11;
  localparam logic [1:0]  PSTATE_D3HOT = 2'h3;
  localparam logic [11:0] CTRL_RESET   = 12'h000;
  localparam logic [7:0]  GPIO_RESET   = 8'h00;

  // Clock-run register: byte 6Fh bit 4 and its companion value
  localparam int CLKRUN_SEL = 28;
  localparam int CLKRUN_VAL = 29;
  localparam logic [1:0] CLKRUN_RESET = 2'h0;

  // Interrupt events
  localparam int IRQ_EJECT = 0;
  localparam int IRQ_LED   = 1;
  localparam int IRQ_GPIO  = 2;
  localparam int IRQ_W     = 3;

  // Synchroniser lanes
  localparam int SY_DCLK  = 0;
  localparam int SY_UCR   = 1;
  localparam int SY_DCR   = 2;
  localparam int SY_LED   = 3;
  localparam int SY_EJECT = 4;
  localparam int SY_EE    = 5;
  localparam int SY_STRAP = 6;
  localparam int SY_GPIO  = 7;
  localparam int SY_W     = 11;
endpackage

//--- bench/bchm_far_model.sv
/*
  Board and far-side model for bchm_top: resolves the two-way pins.
  Assumes a pull-up on the EEPROM data line, the far side driving the
  indicator line when released, and a pull-down on the downstream clock-run line.
*/
`timescale 1ns/10ps
module bchm_far_model (
  // Pins from the block
  input  wire logic [4:0] downstream_clock_out,
  input  wire logic       led_out,
  input  wire logic       led_oe,
  input  wire logic       ee_out,
  input  wire logic       ee_oe,
  input  wire logic       run_out,
  input  wire logic       run_oe,
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe,
  // Levels the far side drives when released
  input  wire logic       led_ext,
  input  wire logic [3:0] gpio_ext,
  // Resolved levels back to the block
  output logic            downstream_clock_in,
  output logic            led_in,
  output logic            ee_in,
  output logic            run_in,
  output logic [3:0]      gpio_in
);
  // feedback from the same clock source
  assign downstream_clock_in = downstream_clock_out[0];
  assign led_in = led_oe ? led_out : led_ext;
  assign ee_in = ee_oe ? ee_out : 1'b1;
  assign run_in = run_oe ? run_out : 1'b0;
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_ext);
endmodule

//--- bench/bchm_top_asserts.sv
/*
  Port checker for bchm_top.
  Assumes it is bound to every bchm_top instance; one clock domain.
*/
`timescale 1ns/10ps
module bchm_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // Observed ports
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [4:0] downstream_clock_out,
  input wire logic       downstream_clock_run_n_oe,
  input wire logic       hotswap_status_n,
  input wire logic       hotswap_led_pin_oe,
  input wire logic       ejector_n,
  input wire logic       scan_test_mode_n,
  input wire logic       scan_enable_out,
  input wire logic       scan_enable_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  clk_phase_a:
    assert property (|downstream_clock_out |=> downstream_clock_out == 5'h00)
      else $error("clock outputs not half rate in phase");
  led_window_a:
    assert property ($fell(hotswap_led_pin_oe) |->
      !hotswap_led_pin_oe [*8] ##1 hotswap_led_pin_oe)
      else $error("indicator release not eight cycles");
  led_gap_a:
    assert property ($rose(hotswap_led_pin_oe) |-> hotswap_led_pin_oe [*8])
      else $error("indicator released again too soon");
  scan_zero_a:
    assert property (scan_enable_oe |-> scan_enable_out == 1'b0)
      else $error("scan enable driven high");
  scan_oe_a:
    assert property (!$past(sys_rst) && !$past(sys_rst, 2) &&
      !$past(sys_rst, 3) |-> scan_enable_oe == $past(scan_test_mode_n, 3))
      else $error("scan enable direction wrong");
  eject_status_a:
    assert property ($fell(ejector_n) |-> ##[1:6] !hotswap_status_n)
      else $error("hot-swap status not raised");
  run_drive_a:
    assert property (!$past(sys_rst) |-> downstream_clock_run_n_oe)
      else $error("clock-run line not driven");
  wait_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
      else $error("bus request not answered");
  wait_single_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low for two cycles");
endmodule

bind bchm_top bchm_checker u_chk (.ref_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .downstream_clock_out, .downstream_clock_run_n_oe,
  .hotswap_status_n, .hotswap_led_pin_oe, .ejector_n, .scan_test_mode_n,
  .scan_enable_out, .scan_enable_oe);

//--- bench/tb.sv
/*
  Self-checking bench for bchm_top with a short indicator period.
  Assumes bchm_far_model resolves the pins and the checker is bound.
*/
`timescale 1ns/10ps
module tb import bchm_pkg::*; ();
  logic        ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [7:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic        avs_waitrequest, irq, dclk_in, ee_in, run_in, led_in;
  logic        upstream_clock_run_n = 0, ejector_n = 1, led_ext = 0;
  logic        power_clock_gate_strap = 1, scan_test_mode_n = 1;
  logic        run_out, run_oe, hotswap_status_n, led_out, led_oe;
  logic        eeprom_serial_clock, ee_out, ee_oe, scan_enable_out;
  logic        scan_enable_oe;
  logic [4:0]  downstream_clock_out;
  logic [3:0]  gpio_in, gpio_out, gpio_oe;
  int          mismatches = 0, check_count = 0;
  logic [7:0]  ra[6] = '{OFS_CTRL, OFS_GPIO, OFS_IRQ_EN, OFS_CLKRUN,
                         8'h20, OFS_IRQ_CLR};
  logic [31:0] rw[6] = '{32'he00, 32'hf5, 32'h6, 32'h3000_0000,
                         32'hffff_ffff, 32'h7};
  logic [31:0] rx[6] = '{32'he00, 32'hf5, 32'h6, 32'h3000_0000, 0, 0};

  bchm_top #(.LED_PERIOD(40)) dut (.ref_clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .irq, .downstream_clock_in(dclk_in), .downstream_clock_out,
    .upstream_clock_run_n, .downstream_clock_run_n_in(run_in),
    .downstream_clock_run_n_out(run_out), .downstream_clock_run_n_oe(run_oe),
    .hotswap_status_n, .hotswap_led_pin_in(led_in),
    .hotswap_led_pin_out(led_out), .hotswap_led_pin_oe(led_oe), .ejector_n,
    .eeprom_serial_clock, .eeprom_serial_data_in(ee_in),
    .eeprom_serial_data_out(ee_out), .eeprom_serial_data_oe(ee_oe),
    .gpio_in, .gpio_out, .gpio_oe, .power_clock_gate_strap,
    .scan_test_mode_n, .scan_enable_out, .scan_enable_oe);
  bchm_far_model far (.downstream_clock_out, .led_out, .led_oe, .ee_out,
    .ee_oe, .run_out, .run_oe, .gpio_out, .gpio_oe, .led_ext,
    .gpio_ext(4'ha), .downstream_clock_in(dclk_in), .led_in, .ee_in,
    .run_in, .gpio_in);

  always #10 ref_clk = ~ref_clk;

  task chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task tog(input logic [4:0] e);
    logic [4:0] a;
    @(negedge ref_clk);
    a = downstream_clock_out;
    @(negedge ref_clk);
    chk("clk_toggle", a ^ downstream_clock_out, e);
  endtask
  task waitoe(input logic v);
    while (led_oe !== v) begin
      @(negedge ref_clk);
    end
  endtask
  task rst(input logic s);
    sys_rst <= 1;
    power_clock_gate_strap <= s;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    give_verdict;
  end

  initial begin
    rst(1'b1);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, ra[i], rw[i]);
      xfer(1'b0, ra[i], 0);
      chk("row_read", q, rx[i]);
    end
    tick(4);
    chk("gpio_pins", {gpio_oe, gpio_out}, 8'hf5);
    chk("ee_pins", {eeprom_serial_clock, ee_out, ee_oe}, 3'h7);
    chk("scan_pins", {scan_enable_oe, scan_enable_out}, 2'h2);
    chk("run_pin", run_out, 1'b1);
    xfer(1'b0, OFS_STATUS, 0);
    chk("status", q & 32'h7ef, 32'h5e5);
    xfer(1'b1, OFS_CLKRUN, 32'h1000_0000);
    tick(2);
    chk("run_pin", run_out, 1'b0);
    xfer(1'b1, OFS_CLKRUN, 0);
    @(posedge ref_clk) upstream_clock_run_n <= 1;
    tick(5);
    chk("run_pin", run_out, 1'b1);
    xfer(1'b0, OFS_STATUS, 0);
    chk("status_run", q[6], 1'b0);
    xfer(1'b1, OFS_CTRL, 32'h1);
    tick(3);
    tog(5'h1e);
    xfer(1'b1, OFS_CTRL, 32'h20);
    tick(3);
    tog(5'h00);
    xfer(1'b1, OFS_CTRL, 32'hc0);
    tick(3);
    chk("clk_out", downstream_clock_out, 5'h00);
    xfer(1'b0, OFS_STATUS, 0);
    chk("status_b2", q[9], 1'b1);
    xfer(1'b1, OFS_IRQ_EN, 0);
    xfer(1'b1, OFS_IRQ_CLR, 32'h7);
    @(posedge ref_clk) ejector_n <= 0;
    tick(8);
    chk("eject_masked", {hotswap_status_n, irq}, 2'h0);
    xfer(1'b1, OFS_IRQ_EN, 32'h1);
    tick(2);
    chk("irq", irq, 1'b1);
    @(posedge ref_clk) ejector_n <= 1;
    xfer(1'b1, OFS_IRQ_CLR, 32'h1);
    tick(2);
    chk("eject_clear", {hotswap_status_n, irq}, 2'h2);
    xfer(1'b1, OFS_CTRL, 32'h100);
    waitoe(1'b1);
    tick(2);
    chk("led_drive", led_out, 1'b1);
    waitoe(1'b0);
    waitoe(1'b1);
    xfer(1'b0, OFS_STATUS, 0);
    chk("led_sample", q[4], 1'b0);
    @(posedge ref_clk) led_ext <= 1;
    waitoe(1'b0);
    waitoe(1'b1);
    tick(10);
    xfer(1'b0, OFS_STATUS, 0);
    chk("led_sample", q[4], 1'b1);
    xfer(1'b0, OFS_IRQ_STAT, 0);
    chk("led_event", q[1], 1'b1);
    rst(1'b0);
    xfer(1'b1, OFS_CTRL, 32'hc0);
    tick(3);
    tog(5'h1f);
    give_verdict;
  end
endmodule
